// File: common/txmsc_pkg.sv
// Shared constants and types for the modulation source control block
package txmsc_pkg;
  // ---------------------------------------------------------------------------
  // Device register map
  // ---------------------------------------------------------------------------
  localparam logic [6:0] TXMSC_A_STATUS   = 7'h03;
  localparam logic [6:0] TXMSC_A_OPMODE   = 7'h07;
  localparam logic [6:0] TXMSC_A_MODCTL   = 7'h71;
  localparam logic [6:0] TXMSC_A_BUFFER   = 7'h7F;
  localparam logic [7:0] TXMSC_MODCTL_RST = 8'h23;
  localparam logic [7:0] TXMSC_OP_MASK    = 8'h0E;
  localparam int         TXMSC_TRCLK_LSB  = 6;
  localparam int         TXMSC_DTMOD_LSB  = 4;
  localparam int         TXMSC_INV_BIT    = 3;
  localparam int         TXMSC_MODTYP_LSB = 0;
  localparam int         TXMSC_OP_TXON    = 3;
  localparam int         TXMSC_OP_RXON    = 2;
  localparam int         TXMSC_OP_PLLON   = 1;
  localparam int         TXMSC_ST_PKSENT  = 2;
  localparam int         TXMSC_ST_PKVALID = 1;
  localparam int         TXMSC_ST_RXERR   = 0;
  localparam logic [8:0] TXMSC_PN_SEED    = 9'h1FF;
  // ---------------------------------------------------------------------------
  // Host register map
  // ---------------------------------------------------------------------------
  localparam logic [1:0] TXMSC_H_DATA     = 2'h0;
  localparam logic [1:0] TXMSC_H_CMD      = 2'h1;
  localparam logic [1:0] TXMSC_H_DIRECT   = 2'h2;
  localparam logic [1:0] TXMSC_H_STATUS   = 2'h3;
  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int TXMSC_CLK_NS        = 50;
  localparam int TXMSC_BIT_NS        = 10000;
  localparam int TXMSC_BIT_CYC       = TXMSC_BIT_NS / TXMSC_CLK_NS;
  localparam int TXMSC_SCLK_HALF_NS  = 400;
  localparam int TXMSC_SCLK_HALF_CYC = TXMSC_SCLK_HALF_NS / TXMSC_CLK_NS;
  // ---------------------------------------------------------------------------
  // Field encodings and states
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {MT_CARRIER, MT_OOK, MT_FSK, MT_GFSK} txmsc_mt_e;
  typedef enum logic [1:0] {SRC_GPIO, SRC_SDI, SRC_BUF, SRC_PN} txmsc_src_e;
  typedef enum logic [1:0] {TC_NONE, TC_GPIO, TC_SDO, TC_IRQ} txmsc_tc_e;
  typedef enum logic [1:0] {ST_IDLE, ST_TUNE, ST_TX, ST_RX} txmsc_st_e;
  typedef enum logic [1:0] {H_IDLE, H_RUN, H_END} txmsc_hst_e;
endpackage

// File: common/txmsc_if.sv
// Pins between the transceiver control logic and its host
`timescale 1ns/1ps
interface txmsc_if;
  logic sclk;
  logic sel_n;
  logic sdi;
  logic gpio_data;
  logic sdo;
  logic sdo_oe_n;
  logic gpio_clk;
  logic irq_n;
  logic sdo_line;

  // Released data-out line idles high
  assign sdo_line = sdo_oe_n ? 1'b1 : sdo;

  modport device (input sclk, sel_n, sdi, gpio_data,
                  output sdo, sdo_oe_n, gpio_clk, irq_n);
  modport host (output sclk, sel_n, sdi, gpio_data,
                input sdo_line, gpio_clk, irq_n);
endinterface

// File: logic/txmsc_device.sv
// Device end: modulation type, data source, bit clock and buffered mode control
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
module txmsc_device
  import txmsc_pkg::*;
#(
  parameter int DEPTH   = 16,
  parameter int BIT_CYC = TXMSC_BIT_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  txmsc_if.device         lnk,
  input  wire logic [7:0] rx_byte_i,
  input  wire logic       rx_byte_we_i,
  input  wire logic       rx_pkt_ok_i,
  input  wire logic       rx_pkt_err_i,
  output logic            tx_active_o,
  output logic            rx_active_o,
  output logic            synth_on_o,
  output logic [1:0]      mod_type_o,
  output logic            mod_bit_o
);
  localparam int         AW   = $clog2(DEPTH);
  localparam int         CW   = $clog2(BIT_CYC);
  localparam logic [AW:0] FULL = DEPTH[AW:0];

  typedef struct packed {
    logic [3:0][2:0]      sy;
    logic [3:0]           flt;
    logic [7:0]           mdc;
    logic [7:0]           op;
    logic [7:0]           sts;
    txmsc_st_e            st;
    logic                 ret_tune;
    logic [CW-1:0]        bcnt;
    logic [2:0]           sbit;
    logic                 hdr;
    logic                 wr;
    logic [6:0]           addr;
    logic [7:0]           sin;
    logic [7:0]           sout;
    logic                 so;
    logic [DEPTH-1:0][7:0] tbuf;
    logic [DEPTH-1:0][7:0] rbuf;
    logic [AW:0]          tw;
    logic [AW:0]          tr;
    logic [AW:0]          rw;
    logic [AW:0]          rr;
    logic [7:0]           tsh;
    logic [2:0]           tleft;
    logic                 bit_r;
    logic [8:0]           pn;
    logic                 txa;
    logic                 rxa;
    logic                 syn;
    logic [1:0]           mtype;
    logic                 mbit;
    logic                 gclk;
    logic                 sdo;
    logic                 sdo_oe_n;
    logic                 irq_n;
  } txmsc_dev_s;

  txmsc_dev_s r_r;
  txmsc_dev_s r_nxt;
  logic [3:0] pin_v;
  logic [7:0] byte_v;
  logic [7:0] rd_v;
  logic [6:0] rd_a;
  logic       rise;
  logic       fall;
  logic       sel;
  logic       tick;
  logic       tclk;
  logic       src_v;
  logic       direct;
  logic       tx_empty;
  logic       tx_full;
  logic       rx_empty;
  logic       rx_full;
  txmsc_src_e src;
  txmsc_tc_e  tcs;
  txmsc_mt_e  mt;

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    r_nxt    = r_r;
    pin_v    = {lnk.gpio_data, lnk.sdi, lnk.sel_n, lnk.sclk};
    byte_v   = {r_r.sin[6:0], r_r.flt[2]};
    rd_a     = r_r.hdr ? byte_v[6:0] : r_r.addr;
    rd_v     = 8'h00;
    tx_empty = (r_r.tw == r_r.tr);
    tx_full  = ((r_r.tw - r_r.tr) == FULL);
    rx_empty = (r_r.rw == r_r.rr);
    rx_full  = ((r_r.rw - r_r.rr) == FULL);
    tick     = (r_r.st == ST_TX) && (r_r.bcnt == '0);
    tclk     = (r_r.bcnt >= CW'(BIT_CYC / 2));
    src      = txmsc_src_e'(r_r.mdc[TXMSC_DTMOD_LSB +: 2]);
    tcs      = txmsc_tc_e'(r_r.mdc[TXMSC_TRCLK_LSB +: 2]);
    mt       = txmsc_mt_e'(r_r.mdc[TXMSC_MODTYP_LSB +: 2]);
    direct   = (src == SRC_GPIO) || (src == SRC_SDI);
    case (src)
      SRC_GPIO: src_v = r_r.flt[3];
      SRC_SDI:  src_v = r_r.flt[1] ? r_r.flt[2] : r_r.bit_r;
      default:  src_v = r_r.bit_r;
    endcase
    // Pin inputs: three stages, a change counts once stages two and three agree
    for (int i = 0; i < 4; i++) begin
      r_nxt.sy[i] = {r_r.sy[i][1:0], pin_v[i]};
      if (r_r.sy[i][1] == r_r.sy[i][2]) begin
        r_nxt.flt[i] = r_r.sy[i][2];
      end
    end
    rise = r_nxt.flt[0] & ~r_r.flt[0];
    fall = ~r_nxt.flt[0] & r_r.flt[0];
    sel  = ~r_r.flt[1];

    // -------------------------------------------------------------------------
    // Serial register port
    // -------------------------------------------------------------------------
    if (!sel) begin
      r_nxt.sbit = 3'd0;
      r_nxt.hdr  = 1'b1;
    end else if (rise) begin
      r_nxt.sin  = byte_v;
      r_nxt.sbit = r_r.sbit + 3'd1;
      if (r_r.sbit == 3'd7) begin
        r_nxt.hdr = 1'b0;
        if (r_r.hdr) begin
          r_nxt.wr   = byte_v[7];
          r_nxt.addr = byte_v[6:0];
        end
        if (r_r.hdr ? !byte_v[7] : !r_r.wr) begin
          case (rd_a)
            TXMSC_A_STATUS: begin
              rd_v      = r_r.sts;
              r_nxt.sts = 8'h00;
            end
            TXMSC_A_OPMODE: rd_v = r_r.op;
            TXMSC_A_MODCTL: rd_v = r_r.mdc;
            TXMSC_A_BUFFER: begin
              if (!rx_empty) begin
                rd_v     = r_r.rbuf[r_r.rr[AW-1:0]];
                r_nxt.rr = r_r.rr + 1'b1;
              end
            end
            default: rd_v = 8'h00;
          endcase
          r_nxt.sout = rd_v;
        end else if (!r_r.hdr) begin
          case (r_r.addr)
            TXMSC_A_MODCTL: r_nxt.mdc = byte_v;
            TXMSC_A_OPMODE: begin
              r_nxt.op       = byte_v & TXMSC_OP_MASK;
              r_nxt.ret_tune = byte_v[TXMSC_OP_PLLON];
              r_nxt.bcnt     = '0;
              r_nxt.tleft    = 3'd0;
              if (byte_v[TXMSC_OP_TXON]) begin
                r_nxt.st = ST_TX;
              end else if (byte_v[TXMSC_OP_RXON]) begin
                r_nxt.st = ST_RX;
              end else if (byte_v[TXMSC_OP_PLLON]) begin
                r_nxt.st = ST_TUNE;
              end else begin
                r_nxt.st = ST_IDLE;
              end
            end
            TXMSC_A_BUFFER: begin
              if (!tx_full) begin
                r_nxt.tbuf[r_r.tw[AW-1:0]] = byte_v;
                r_nxt.tw                  = r_r.tw + 1'b1;
              end
            end
            default: ;
          endcase
        end
      end
    end else if (fall) begin
      r_nxt.so   = r_r.sout[7];
      r_nxt.sout = {r_r.sout[6:0], 1'b0};
    end

    // -------------------------------------------------------------------------
    // Transmit bit engine
    // -------------------------------------------------------------------------
    if (r_r.st == ST_TX) begin
      r_nxt.bcnt = tick ? CW'(BIT_CYC - 1) : r_r.bcnt - 1'b1;
      if (tick) begin
        case (src)
          SRC_PN: begin
            r_nxt.bit_r = r_r.pn[8];
            r_nxt.pn    = {r_r.pn[7:0], r_r.pn[8] ^ r_r.pn[4]};
          end
          SRC_BUF: begin
            if (r_r.tleft != 3'd0) begin
              r_nxt.bit_r = r_r.tsh[7];
              r_nxt.tsh   = {r_r.tsh[6:0], 1'b0};
              r_nxt.tleft = r_r.tleft - 3'd1;
            end else if (!tx_empty) begin
              r_nxt.bit_r = r_r.tbuf[r_r.tr[AW-1:0]][7];
              r_nxt.tsh   = {r_r.tbuf[r_r.tr[AW-1:0]][6:0], 1'b0};
              r_nxt.tleft = 3'd7;
              r_nxt.tr    = r_r.tr + 1'b1;
            end else begin
              r_nxt.sts[TXMSC_ST_PKSENT] = 1'b1;
              r_nxt.op[TXMSC_OP_TXON]    = 1'b0;
              r_nxt.st = r_r.ret_tune ? ST_TUNE : ST_IDLE;
            end
          end
          default: begin
            if (tcs != TC_NONE) begin
              r_nxt.bit_r = src_v;
            end
          end
        endcase
      end
      if (direct && tcs == TC_NONE && mt == MT_FSK) begin
        r_nxt.bit_r = src_v;
      end
    end

    // -------------------------------------------------------------------------
    // Receive side
    // -------------------------------------------------------------------------
    if (r_r.st == ST_RX) begin
      if (rx_byte_we_i && !rx_full && src == SRC_BUF) begin
        r_nxt.rbuf[r_r.rw[AW-1:0]] = rx_byte_i;
        r_nxt.rw                  = r_r.rw + 1'b1;
      end
      if (rx_pkt_err_i) begin
        r_nxt.sts[TXMSC_ST_RXERR] = 1'b1;
      end
      if (rx_pkt_ok_i) begin
        r_nxt.sts[TXMSC_ST_PKVALID] = 1'b1;
        if (src == SRC_BUF) begin
          r_nxt.op[TXMSC_OP_RXON] = 1'b0;
          r_nxt.st = r_r.op[TXMSC_OP_PLLON] ? ST_TUNE : ST_IDLE;
        end
      end
    end

    // -------------------------------------------------------------------------
    // Registered outputs
    // -------------------------------------------------------------------------
    r_nxt.txa   = (r_nxt.st == ST_TX);
    r_nxt.rxa   = (r_nxt.st == ST_RX);
    r_nxt.syn   = (r_nxt.st != ST_IDLE);
    r_nxt.mtype = r_r.mdc[TXMSC_MODTYP_LSB +: 2];
    r_nxt.mbit  = (r_r.st == ST_TX) && (mt != MT_CARRIER) &&
                  (r_r.bit_r ^ r_r.mdc[TXMSC_INV_BIT]);
    r_nxt.gclk  = (r_r.st == ST_TX) && (tcs == TC_GPIO) && tclk;
    if (sel) begin
      r_nxt.sdo      = r_r.so;
      r_nxt.sdo_oe_n = 1'b0;
    end else if (r_r.st == ST_TX && tcs == TC_SDO) begin
      r_nxt.sdo      = tclk;
      r_nxt.sdo_oe_n = 1'b0;
    end else begin
      r_nxt.sdo      = 1'b1;
      r_nxt.sdo_oe_n = 1'b1;
    end
    r_nxt.irq_n = (r_r.st == ST_TX && tcs == TC_IRQ) ? tclk : ~|r_nxt.sts;
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      r_r          <= '0;
      r_r.sy[1]    <= 3'b111;
      r_r.flt[1]   <= 1'b1;
      r_r.mdc      <= TXMSC_MODCTL_RST;
      r_r.hdr      <= 1'b1;
      r_r.pn       <= TXMSC_PN_SEED;
      r_r.sdo      <= 1'b1;
      r_r.sdo_oe_n <= 1'b1;
      r_r.irq_n    <= 1'b1;
      r_r.mtype    <= TXMSC_MODCTL_RST[1:0];
    end else begin
      r_r <= r_nxt;
    end
  end

  assign lnk.sdo      = r_r.sdo;
  assign lnk.sdo_oe_n = r_r.sdo_oe_n;
  assign lnk.gpio_clk = r_r.gclk;
  assign lnk.irq_n    = r_r.irq_n;
  assign tx_active_o  = r_r.txa;
  assign rx_active_o  = r_r.rxa;
  assign synth_on_o   = r_r.syn;
  assign mod_type_o   = r_r.mtype;
  assign mod_bit_o    = r_r.mbit;

endmodule // txmsc_device

// File: logic/txmsc_host.sv
// Host end: serial register master and direct transmit data feeder
`timescale 1ns/1ps
module txmsc_host
  import txmsc_pkg::*;
#(
  parameter int HALF = TXMSC_SCLK_HALF_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  txmsc_if.host           lnk,
  input  wire logic [1:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       we_i,
  input  wire logic       re_i,
  output logic [7:0]      rdata_o
);
  localparam int DW = $clog2(HALF);

  typedef struct packed {
    logic [2:0][2:0] sy;
    logic [2:0]      flt;
    txmsc_hst_e      st;
    logic [DW-1:0]   div;
    logic            sclk;
    logic            sel_n;
    logic            sdi;
    logic [3:0]      nfall;
    logic [15:0]     sho;
    logic [7:0]      shi;
    logic            rd;
    logic [7:0]      wdat;
    logic [7:0]      rdb;
    logic [3:0]      dirc;
    logic            dout;
    logic            cprev;
    logic            taken;
    logic [7:0]      rdata;
  } txmsc_host_s;

  txmsc_host_s r_r;
  txmsc_host_s r_nxt;
  logic [2:0]  pin_v;
  logic        cv;

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    r_nxt       = r_r;
    r_nxt.rdata = 8'h00;
    pin_v       = {lnk.irq_n, lnk.gpio_clk, lnk.sdo_line};
    for (int i = 0; i < 3; i++) begin
      r_nxt.sy[i] = {r_r.sy[i][1:0], pin_v[i]};
      if (r_r.sy[i][1] == r_r.sy[i][2]) begin
        r_nxt.flt[i] = r_r.sy[i][2];
      end
    end
    if (re_i) begin
      case (addr_i)
        TXMSC_H_DATA:   r_nxt.rdata = r_r.rdb;
        TXMSC_H_CMD:    r_nxt.rdata = {7'h00, r_r.st != H_IDLE};
        TXMSC_H_DIRECT: r_nxt.rdata = {4'h0, r_r.dirc};
        default:        r_nxt.rdata = {6'h00, r_r.taken, r_r.st != H_IDLE};
      endcase
    end
    if (we_i) begin
      case (addr_i)
        TXMSC_H_DATA: r_nxt.wdat = wdata_i;
        TXMSC_H_CMD: begin
          if (r_r.st == H_IDLE) begin
            r_nxt.st    = H_RUN;
            r_nxt.sel_n = 1'b0;
            r_nxt.sclk  = 1'b0;
            r_nxt.div   = DW'(HALF - 1);
            r_nxt.nfall = 4'd0;
            r_nxt.rd    = ~wdata_i[7];
            r_nxt.sho   = {wdata_i, r_r.wdat};
          end
        end
        TXMSC_H_DIRECT: begin
          r_nxt.dirc  = wdata_i[3:0];
          r_nxt.taken = 1'b0;
        end
        default: ;
      endcase
    end

    // -------------------------------------------------------------------------
    // Serial frame: header then one data byte, sampled by the device on rise
    // -------------------------------------------------------------------------
    case (r_r.st)
      H_RUN: begin
        if (r_r.div == '0) begin
          r_nxt.div  = DW'(HALF - 1);
          r_nxt.sclk = ~r_r.sclk;
          if (r_r.sclk) begin
            r_nxt.shi   = {r_r.shi[6:0], r_r.flt[0]};
            r_nxt.sho   = {r_r.sho[14:0], 1'b0};
            r_nxt.nfall = r_r.nfall + 4'd1;
            if (r_r.nfall == 4'd15) begin
              r_nxt.st = H_END;
            end
          end
        end else begin
          r_nxt.div = r_r.div - 1'b1;
        end
      end
      H_END: begin
        if (r_r.div == '0) begin
          r_nxt.sel_n = 1'b1;
          r_nxt.st    = H_IDLE;
          if (r_r.rd) begin
            r_nxt.rdb = r_r.shi;
          end
        end else begin
          r_nxt.div = r_r.div - 1'b1;
        end
      end
      default: ;
    endcase

    // -------------------------------------------------------------------------
    // Direct data: next bit presented on the falling edge of the bit clock, or at once when no bit clock is selected
    // -------------------------------------------------------------------------
    case (txmsc_tc_e'(r_r.dirc[2:1]))
      TC_GPIO: cv = r_r.flt[1];
      TC_SDO:  cv = r_r.flt[0] & r_r.sel_n;
      TC_IRQ:  cv = r_r.flt[2];
      default: cv = 1'b0;
    endcase
    r_nxt.cprev = cv;
    if (r_r.dirc[2:1] == 2'b00) begin
      r_nxt.dout = r_r.dirc[0];
    end else if (r_r.cprev && !cv) begin
      r_nxt.dout  = r_r.dirc[0];
      r_nxt.taken = 1'b1;
    end
    if (r_nxt.st != H_IDLE) begin
      r_nxt.sdi = r_nxt.sho[15];
    end else begin
      r_nxt.sdi = r_r.dirc[3] ? r_nxt.dout : 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      r_r       <= '0;
      r_r.sy    <= '1;
      r_r.sy[1] <= 3'b000;
      r_r.flt   <= 3'b101;
      r_r.sel_n <= 1'b1;
      r_r.sdi   <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign lnk.sclk      = r_r.sclk;
  assign lnk.sel_n     = r_r.sel_n;
  assign lnk.sdi       = r_r.sdi;
  assign lnk.gpio_data = r_r.dout;
  assign rdata_o       = r_r.rdata;

endmodule // txmsc_host

// File: verification/txmsc_chk.sv
// Link-level checks between the host end and the device end
`timescale 1ns/1ps
module txmsc_chk (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic sdi,
  input wire logic sdo_oe_n,
  input wire logic gpio_clk,
  input wire logic irq_n
);
  logic       sclk_q_r;
  logic [4:0] rise_r;

  // ---------------------------------------------------------------------------
  // Serial clock rises counted within one frame
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    sclk_q_r <= sclk;
    if (!rst_n_i || sel_n) begin
      rise_r <= 5'h00;
    end else if (sclk && !sclk_q_r) begin
      rise_r <= rise_r + 5'h01;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_frame_len: assert property ($rose(sel_n) |-> rise_r == 5'h10)
    else $error("frame did not carry sixteen serial clocks");
  a_sclk_high: assert property ($rose(sclk) |-> sclk[*8])
    else $error("serial clock high phase wrong");
  a_sclk_low: assert property ($fell(sclk) && !sel_n |-> !sclk[*8])
    else $error("serial clock low phase wrong");
  a_sclk_idle: assert property (sel_n |-> !sclk)
    else $error("serial clock moves while deselected");
  a_sdi_stable: assert property ($rose(sclk) |-> $stable(sdi)[*8])
    else $error("serial data moved around the sampling edge");
  a_bitclk_high: assert property ($rose(gpio_clk) |-> gpio_clk[*8] ##1 !gpio_clk)
    else $error("bit clock high phase wrong");
  a_bitclk_low: assert property ($fell(gpio_clk) |-> !gpio_clk[*8] ##1 gpio_clk)
    else $error("bit clock low phase wrong");
  a_reset_idle: assert property ($rose(rst_n_i) |-> sdo_oe_n && irq_n && !gpio_clk && sel_n)
    else $error("pins not idle after reset");
endmodule // txmsc_chk

// File: verification/txmsc_bench.sv
// Self-checking bench for the host and device ends
`timescale 1ns/1ps
module txmsc_bench;
  import txmsc_pkg::*;
  localparam logic [7:0] PAT = 8'hB4;
  logic       clk_i;
  logic       rst_n_i;
  logic [1:0] addr;
  logic [7:0] wdata;
  logic       we;
  logic       re;
  logic [7:0] rdata;
  logic       ok;
  logic       perr;
  logic       tx_act;
  logic       rx_act;
  logic       synth;
  logic [1:0] mtype;
  logic       mbit;
  logic [7:0] rxb;
  logic       rxwe;
  int         err_count = 0;
  int         checked = 0;
  int         cyc = 0;

  txmsc_if lnk ();
  txmsc_device #(.DEPTH(16), .BIT_CYC(16)) u_txmsc_device (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .lnk(lnk.device), .rx_byte_i(rxb), .rx_byte_we_i(rxwe), .rx_pkt_ok_i(ok),
    .rx_pkt_err_i(perr), .tx_active_o(tx_act), .rx_active_o(rx_act), .synth_on_o(synth),
    .mod_type_o(mtype), .mod_bit_o(mbit));
  txmsc_host #(.HALF(8)) u_txmsc_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .lnk(lnk.host),
    .addr_i(addr), .wdata_i(wdata), .we_i(we), .re_i(re), .rdata_o(rdata));
  txmsc_chk u_txmsc_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .sclk(lnk.sclk), .sel_n(lnk.sel_n),
    .sdi(lnk.sdi), .sdo_oe_n(lnk.sdo_oe_n), .gpio_clk(lnk.gpio_clk), .irq_n(lnk.irq_n));

  initial clk_i = 1'b0;
  always #25 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check1(input string name, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask

  // ---------------------------------------------------------------------------
  // Host port and serial frame helpers
  // ---------------------------------------------------------------------------
  task automatic hwr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk_i);
    we <= 1'b0;
  endtask

  task automatic hrd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    re <= 1'b1;
    @(posedge clk_i);
    re <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic wait_idle();
    logic [7:0] s;
    int n;
    s = 8'h01;
    for (n = 0; n < 300 && s[0] !== 1'b0; n++) hrd(TXMSC_H_STATUS, s);
    check1("host busy", 1'b0, s[0]);
  endtask

  task automatic dwr(input logic [6:0] a, input logic [7:0] d);
    hwr(TXMSC_H_DATA, d);
    hwr(TXMSC_H_CMD, {1'b1, a});
    wait_idle();
  endtask

  task automatic drd(input logic [6:0] a, output logic [7:0] d);
    hwr(TXMSC_H_CMD, {1'b0, a});
    wait_idle();
    hrd(TXMSC_H_DATA, d);
  endtask

  task automatic wait_tx(input logic lvl);
    int n;
    for (n = 0; n < 600 && tx_act !== lvl; n++) @(posedge clk_i) #1;
    check1("tx active", lvl, tx_act);
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_types();
    logic [7:0] d;
    int k;
    drd(TXMSC_A_MODCTL, d);
    check8("modctl reset", TXMSC_MODCTL_RST, d);
    for (k = 0; k < 4; k++) begin
      dwr(TXMSC_A_MODCTL, 8'h20 | 8'(k));
      check8("mod type", 8'(k), {6'h00, mtype});
      check1("idle bit", 1'b0, mbit);
    end
  endtask

  task automatic t_txbuf(input logic [7:0] opm, input logic inv, input logic syn);
    logic [7:0] d;
    int k;
    dwr(TXMSC_A_MODCTL, {4'h2, inv, 3'h2});
    dwr(TXMSC_A_BUFFER, PAT);
    hwr(TXMSC_H_DATA, opm);
    hwr(TXMSC_H_CMD, {1'b1, TXMSC_A_OPMODE});
    wait_tx(1'b1);
    for (k = 0; k < 8; k++) begin
      repeat (8) @(posedge clk_i);
      #1 check1("tx bit", PAT[7-k] ^ inv, mbit);
      repeat (8) @(posedge clk_i);
    end
    wait_tx(1'b0);
    check1("synth after send", syn, synth);
    wait_idle();
    drd(TXMSC_A_STATUS, d);
    check8("status sent", 8'h04, d);
    drd(TXMSC_A_OPMODE, d);
    check8("opmode after send", opm & 8'h06, d);
  endtask

  task automatic t_rx();
    logic [7:0] d;
    dwr(TXMSC_A_OPMODE, 8'h04);
    @(posedge clk_i) perr <= 1'b1;
    @(posedge clk_i) perr <= 1'b0;
    @(posedge clk_i) begin
      rxb  <= 8'h5C;
      rxwe <= 1'b1;
    end
    @(posedge clk_i) rxwe <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1 check1("rx after error", 1'b1, rx_act);
    check1("irq on error", 1'b0, lnk.irq_n);
    drd(TXMSC_A_STATUS, d);
    check8("status error", 8'h01, d);
    check1("irq cleared", 1'b1, lnk.irq_n);
    @(posedge clk_i) ok <= 1'b1;
    @(posedge clk_i) ok <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1 check1("rx after valid", 1'b0, rx_act);
    check1("idle after valid", 1'b0, synth);
    drd(TXMSC_A_BUFFER, d);
    check8("rx buffer", 8'h5C, d);
    drd(TXMSC_A_BUFFER, d);
    check8("rx buffer empty", 8'h00, d);
  endtask

  task automatic t_pn();
    logic [8:0] p;
    int k;
    p = TXMSC_PN_SEED;
    dwr(TXMSC_A_MODCTL, 8'h32);
    hwr(TXMSC_H_DATA, 8'h08);
    hwr(TXMSC_H_CMD, {1'b1, TXMSC_A_OPMODE});
    wait_tx(1'b1);
    for (k = 0; k < 16; k++) begin
      repeat (8) @(posedge clk_i);
      #1 check1("pn bit", p[8], mbit);
      p = {p[7:0], p[8] ^ p[4]};
      repeat (8) @(posedge clk_i);
    end
    dwr(TXMSC_A_OPMODE, 8'h00);
  endtask

  task automatic t_direct();
    logic [7:0] d;
    dwr(TXMSC_A_MODCTL, 8'hD3);
    hwr(TXMSC_H_DIRECT, 8'h0F);
    dwr(TXMSC_A_OPMODE, 8'h08);
    repeat (64) @(posedge clk_i);
    #1 check1("irq clocked one", 1'b1, mbit);
    dwr(TXMSC_A_MODCTL, 8'h93);
    hwr(TXMSC_H_DIRECT, 8'h0C);
    repeat (64) @(posedge clk_i);
    #1 check1("sdo clocked zero", 1'b0, mbit);
    dwr(TXMSC_A_OPMODE, 8'h00);
    dwr(TXMSC_A_MODCTL, 8'h42);
    hwr(TXMSC_H_DIRECT, 8'h03);
    dwr(TXMSC_A_OPMODE, 8'h08);
    repeat (64) @(posedge clk_i);
    #1 check1("direct one", 1'b1, mbit);
    hwr(TXMSC_H_DIRECT, 8'h02);
    repeat (64) @(posedge clk_i);
    #1 check1("direct zero", 1'b0, mbit);
    check1("direct stays in tx", 1'b1, tx_act);
    hrd(TXMSC_H_STATUS, d);
    check8("bit taken", 8'h02, d & 8'h02);
    hwr(TXMSC_H_DIRECT, 8'h03);
    dwr(TXMSC_A_MODCTL, 8'h40);
    repeat (64) @(posedge clk_i);
    #1 check1("carrier", 1'b0, mbit);
  endtask

  initial begin
    rst_n_i = 1'b0;
    addr = 2'h0;
    wdata = 8'h00;
    we = 1'b0;
    re = 1'b0;
    ok = 1'b0;
    perr = 1'b0;
    rxb = 8'h00;
    rxwe = 1'b0;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1 check8("mod type reset", 8'h03, {6'h00, mtype});
    t_types();
    t_txbuf(8'h0A, 1'b0, 1'b1);
    t_txbuf(8'h08, 1'b1, 1'b0);
    t_rx();
    t_pn();
    t_direct();
    print_verdict();
  end
endmodule // txmsc_bench
